// [dpfl_regs.vh]
`ifndef DPFL_REGS_VH
`define DPFL_REGS_VH

`define DPFL_ADDR_PHASE0  8'h00
`define DPFL_ADDR_PHASE3  8'h03
`define DPFL_ADDR_FREQ0   8'h04
`define DPFL_ADDR_FREQ3   8'h07
`define DPFL_ADDR_LOCK0   8'h08
`define DPFL_ADDR_LOCK3   8'h0B
`define DPFL_ADDR_DELAY   8'h0C
`define DPFL_ADDR_STATUS  8'h0D
`define DPFL_ADDR_EVENT   8'h0E

`define DPFL_PHASE_W      30
`define DPFL_FREQ_W       29
`define DPFL_TIMER_RST    16'h00FF
`define DPFL_THRESH_RST   16'h0155
`define DPFL_DELAY_RST    8'h1F

`define DPFL_EV_LOL_BIT   0
`define DPFL_EV_STCH_BIT  3

`define DPFL_ST_FREERUN   3'h0
`define DPFL_ST_NORMAL    3'h1
`define DPFL_ST_HOLDOVER  3'h2
`define DPFL_ST_WRFREQ    3'h3
`define DPFL_ST_ACQUIRE   3'h4
`define DPFL_ST_HITLESS   3'h5

`define DPFL_MS_NS        1000000
`define DPFL_CLK_NS       10

`endif

// [dpfl_lock_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "dpfl_regs.vh"

module dpfl_lock_regs #(
  parameter MS_CYCLES = `DPFL_MS_NS / `DPFL_CLK_NS,
  parameter ERR_W     = 24
) (
  input  wire                    ref_clk,
  input  wire                    rst_b,
  input  wire [7:0]              reg_addr,
  input  wire                    reg_wr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  input  wire [ERR_W-1:0]        phase_err_abs,
  input  wire                    ref_valid,
  input  wire                    ref_select,
  input  wire                    dco_mode,
  input  wire                    hitless_enable,
  input  wire                    hitless_active,
  input  wire                    filter_swap_enable,
  output reg  [29:0]             phase_adjust_out,
  output reg                     phase_apply,
  output reg  [28:0]             freq_word_out,
  output reg                     freq_apply,
  output wire [7:0]              tdc_delay_out,
  output wire [2:0]              loop_state,
  output wire                    lock_out,
  output wire                    filter_normal_sel
);

  reg  [31:0]       phase_stage_q;
  reg  [31:0]       freq_stage_q;
  reg  [15:0]       timer_q;
  reg  [15:0]       thresh_q;
  reg  [7:0]        delay_q;
  reg  [2:0]        state_q;
  reg  [2:0]        state_d;
  reg               lock_q;
  reg               lock_d;
  reg               ev_lol_q;
  reg               ev_stch_q;
  reg  [31:0]       tick_cnt_q;
  reg               tick_q;
  reg  [15:0]       ms_cnt_q;
  reg               clr_run;
  wire              err_ok;
  wire              half_done;
  wire              wr_phase3;
  wire              wr_freq3;
  wire [7:0]        status_byte;
  wire [7:0]        event_byte;
  wire [18:0]       thresh_steps;

  // threshold counts eight converter steps, error arrives in steps
  assign thresh_steps = {thresh_q, 3'b000};
  assign err_ok       = ({{19{1'b0}}, phase_err_abs} < {{ERR_W{1'b0}}, thresh_steps});
  assign half_done    = (ms_cnt_q >= {1'b0, timer_q[15:1]});
  assign wr_phase3    = reg_wr && (reg_addr == `DPFL_ADDR_PHASE3);
  assign wr_freq3     = reg_wr && (reg_addr == `DPFL_ADDR_FREQ3);

  // staging copies plus live threshold, timer and delay registers, byte-addressed
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_stage_q <= 32'h00000000;
      freq_stage_q  <= 32'h00000000;
      timer_q       <= `DPFL_TIMER_RST;
      thresh_q      <= `DPFL_THRESH_RST;
      delay_q       <= `DPFL_DELAY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h00: phase_stage_q[7:0]   <= reg_wdata;
        8'h01: phase_stage_q[15:8]  <= reg_wdata;
        8'h02: phase_stage_q[23:16] <= reg_wdata;
        8'h03: phase_stage_q[31:24] <= {2'b00, reg_wdata[5:0]};
        8'h04: freq_stage_q[7:0]    <= reg_wdata;
        8'h05: freq_stage_q[15:8]   <= reg_wdata;
        8'h06: freq_stage_q[23:16]  <= reg_wdata;
        8'h07: freq_stage_q[31:24]  <= {3'b000, reg_wdata[4:0]};
        8'h08: thresh_q[7:0]        <= reg_wdata;
        8'h09: thresh_q[15:8]       <= reg_wdata;
        8'h0A: timer_q[7:0]         <= reg_wdata;
        8'h0B: timer_q[15:8]        <= reg_wdata;
        8'h0C: delay_q              <= reg_wdata;
        default: ;
      endcase
    end
  end

  // live values move only on top-byte writes
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_adjust_out <= 30'h00000000;
      phase_apply      <= 1'b0;
      freq_word_out    <= 29'h00000000;
      freq_apply       <= 1'b0;
    end else begin
      phase_apply <= 1'b0;
      freq_apply  <= 1'b0;
      // hitless switching owns phase; the write is dropped, not queued
      if (wr_phase3 && !hitless_enable) begin
        phase_adjust_out <= {reg_wdata[5:0], phase_stage_q[23:0]};
        phase_apply      <= 1'b1;
      end
      if (wr_freq3) begin
        freq_word_out <= {reg_wdata[4:0], freq_stage_q[23:0]};
        freq_apply    <= 1'b1;
      end
    end
  end

  // millisecond tick
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == MS_CYCLES - 1) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q     <= 1'b0;
    end
  end

  // next state and lock
  always @* begin
    state_d = state_q;
    lock_d  = lock_q;
    clr_run = 1'b0;
    case (state_q)
      `DPFL_ST_FREERUN, `DPFL_ST_HOLDOVER: begin
        lock_d = 1'b0;
        if (dco_mode) begin
          state_d = `DPFL_ST_WRFREQ;
        end else if (ref_valid) begin
          state_d = `DPFL_ST_ACQUIRE;
          clr_run = 1'b1;
        end
      end
      `DPFL_ST_WRFREQ: begin
        lock_d = 1'b0;
        if (!dco_mode) begin
          state_d = ref_valid ? `DPFL_ST_ACQUIRE : `DPFL_ST_FREERUN;
          clr_run = 1'b1;
        end
      end
      `DPFL_ST_ACQUIRE: begin
        if (dco_mode) begin
          state_d = `DPFL_ST_WRFREQ;
        end else if (!ref_valid) begin
          state_d = `DPFL_ST_FREERUN;
        end else if (!err_ok) begin
          clr_run = 1'b1;
        end else if (half_done) begin
          state_d = `DPFL_ST_NORMAL;
          clr_run = 1'b1;
        end
      end
      `DPFL_ST_NORMAL: begin
        if (dco_mode) begin
          state_d = `DPFL_ST_WRFREQ;
          lock_d  = 1'b0;
        end else if (!ref_valid) begin
          state_d = lock_q ? `DPFL_ST_HOLDOVER : `DPFL_ST_FREERUN;
          lock_d  = 1'b0;
        end else if (hitless_active && hitless_enable) begin
          state_d = `DPFL_ST_HITLESS;
        end else if (!err_ok) begin
          // losing the threshold restarts acquisition
          state_d = `DPFL_ST_ACQUIRE;
          lock_d  = 1'b0;
          clr_run = 1'b1;
        end else if (half_done && !lock_q) begin
          lock_d  = 1'b1;
        end
      end
      `DPFL_ST_HITLESS: begin
        if (!hitless_active || !hitless_enable) begin
          state_d = `DPFL_ST_NORMAL;
        end
      end
      default: begin
        state_d = `DPFL_ST_FREERUN;
        lock_d  = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q  <= `DPFL_ST_FREERUN;
      lock_q   <= 1'b0;
      ms_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      lock_q  <= lock_d;
      if (clr_run) begin
        ms_cnt_q <= 16'h0000;
      end else if (tick_q && ms_cnt_q != 16'hFFFF) begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
    end
  end

  // events: set wins over a same-cycle clear
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ev_lol_q  <= 1'b0;
      ev_stch_q <= 1'b0;
    end else begin
      if (lock_q && !lock_d) begin
        ev_lol_q <= 1'b1;
      end else if (reg_wr && reg_addr == `DPFL_ADDR_EVENT && reg_wdata[`DPFL_EV_LOL_BIT]) begin
        ev_lol_q <= 1'b0;
      end
      if (state_d != state_q) begin
        ev_stch_q <= 1'b1;
      end else if (reg_wr && reg_addr == `DPFL_ADDR_EVENT && reg_wdata[`DPFL_EV_STCH_BIT]) begin
        ev_stch_q <= 1'b0;
      end
    end
  end

  assign status_byte = {1'b0, state_q, 2'b00, ref_select, lock_q};
  assign event_byte  = {4'h0, ev_stch_q, 2'b00, ev_lol_q};

  // read data one cycle after the strobe
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        8'h00:   reg_rdata <= phase_stage_q[7:0];
        8'h01:   reg_rdata <= phase_stage_q[15:8];
        8'h02:   reg_rdata <= phase_stage_q[23:16];
        8'h03:   reg_rdata <= phase_stage_q[31:24];
        8'h04:   reg_rdata <= freq_stage_q[7:0];
        8'h05:   reg_rdata <= freq_stage_q[15:8];
        8'h06:   reg_rdata <= freq_stage_q[23:16];
        8'h07:   reg_rdata <= freq_stage_q[31:24];
        8'h08:   reg_rdata <= thresh_q[7:0];
        8'h09:   reg_rdata <= thresh_q[15:8];
        8'h0A:   reg_rdata <= timer_q[7:0];
        8'h0B:   reg_rdata <= timer_q[15:8];
        8'h0C:   reg_rdata <= delay_q;
        8'h0D:   reg_rdata <= status_byte;
        8'h0E:   reg_rdata <= event_byte;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign tdc_delay_out     = delay_q;
  assign loop_state        = state_q;
  assign lock_out          = lock_q;
  assign filter_normal_sel = filter_swap_enable && (state_q == `DPFL_ST_NORMAL || state_q == `DPFL_ST_HITLESS);

endmodule // dpfl_lock_regs
`default_nettype wire

// [dpfl_lock_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module dpfl_lock_regs_chk #(
  parameter MS_CYCLES = 10,
  parameter ERR_W     = 24
) (
  input wire        ref_clk,
  input wire        rst_b,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [7:0]  reg_wdata,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        hitless_enable,
  input wire        filter_swap_enable,
  input wire [29:0] phase_adjust_out,
  input wire        phase_apply,
  input wire [28:0] freq_word_out,
  input wire        freq_apply,
  input wire [7:0]  tdc_delay_out,
  input wire [2:0]  loop_state,
  input wire        lock_out,
  input wire        filter_normal_sel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_phase_commit: assert property (reg_wr && reg_addr == 8'h03 && !hitless_enable |=>
    phase_apply && phase_adjust_out[29:24] == $past(reg_wdata[5:0])) else $error("phase commit missing");
  a_phase_cause: assert property (phase_apply |->
    $past(reg_wr && reg_addr == 8'h03 && !hitless_enable)) else $error("phase apply without cause");
  a_phase_held: assert property (!phase_apply |-> $stable(phase_adjust_out)) else $error("phase moved");
  a_freq_commit: assert property (reg_wr && reg_addr == 8'h07 |=>
    freq_apply && freq_word_out[28:24] == $past(reg_wdata[4:0])) else $error("freq commit missing");
  a_freq_held: assert property (!freq_apply |-> $stable(freq_word_out)) else $error("freq moved");
  a_delay_write: assert property (reg_wr && reg_addr == 8'h0C |=>
    tdc_delay_out == $past(reg_wdata)) else $error("delay not written");
  a_status_read: assert property (reg_rd && reg_addr == 8'h0D |=> reg_rdata[7] == 1'b0 &&
    reg_rdata[6:4] == $past(loop_state) && reg_rdata[0] == $past(lock_out)) else $error("status mismatch");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h0E |=> reg_rdata == 8'h00) else $error("unmapped");
  a_lock_normal: assert property ($rose(lock_out) |-> loop_state == 3'h1) else $error("lock outside normal");
  a_filter_swap: assert property (filter_normal_sel ==
    (filter_swap_enable && (loop_state == 3'h1 || loop_state == 3'h5))) else $error("filter select wrong");
endmodule // dpfl_lock_regs_chk
bind dpfl_lock_regs dpfl_lock_regs_chk #(.MS_CYCLES(MS_CYCLES), .ERR_W(ERR_W)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hitless_enable(hitless_enable),
  .filter_swap_enable(filter_swap_enable), .phase_adjust_out(phase_adjust_out), .phase_apply(phase_apply),
  .freq_word_out(freq_word_out), .freq_apply(freq_apply), .tdc_delay_out(tdc_delay_out),
  .loop_state(loop_state), .lock_out(lock_out), .filter_normal_sel(filter_normal_sel));
`default_nettype wire

// [dpfl_lock_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module dpfl_lock_regs_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [23:0] err_abs = 24'h000000;
  logic        ref_valid = 1'b0;
  logic        ref_sel = 1'b0;
  logic        hl_en = 1'b0;
  logic        swap_en = 1'b0;
  logic        dco = 1'b0;
  logic        hl_act = 1'b0;
  wire  [7:0]  rdata;
  wire  [29:0] ph_out;
  wire  [28:0] fq_out;
  wire  [7:0]  dly;
  wire  [2:0]  st;
  wire         ph_ap, fq_ap, lck, fsel;
  int          err_total = 0, checked = 0, cyc = 0;

  // short ms tick keeps lock timing within a few hundred cycles
  dpfl_lock_regs #(.MS_CYCLES(10), .ERR_W(24)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(rdata), .phase_err_abs(err_abs), .ref_valid(ref_valid),
    .ref_select(ref_sel), .dco_mode(dco), .hitless_enable(hl_en), .hitless_active(hl_act),
    .filter_swap_enable(swap_en), .phase_adjust_out(ph_out), .phase_apply(ph_ap), .freq_word_out(fq_out),
    .freq_apply(fq_ap), .tdc_delay_out(dly), .loop_state(st), .lock_out(lck), .filter_normal_sel(fsel));

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk({24'h0, rdata}, {24'h0, exp});
  endtask
  task close_out;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task t_reset;
    rd(8'h0C, 8'h1F);
    rd(8'h08, 8'h55);
    rd(8'h09, 8'h01);
    rd(8'h0A, 8'hFF);
    rd(8'h0D, 8'h00);
    rd(8'h3C, 8'h00);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'h00);
    wr(8'h0C, 8'hA5);
    chk({24'h0, dly}, 32'hA5);
    $display("reset test done");
  endtask
  task t_phase;
    wr(8'h00, 8'h78);
    wr(8'h01, 8'h56);
    wr(8'h02, 8'h34);
    chk({2'b0, ph_out}, 32'h0);
    wr(8'h03, 8'hF2);
    chk({31'h0, ph_ap}, 32'h1);
    chk({2'b0, ph_out}, 32'h32345678);
    rd(8'h03, 8'h32);
    hl_en = 1'b1;
    wr(8'h03, 8'h01);
    chk({31'h0, ph_ap}, 32'h0);
    chk({2'b0, ph_out}, 32'h32345678);
    hl_en = 1'b0;
    $display("phase test done");
  endtask
  task t_freq;
    wr(8'h04, 8'h11);
    wr(8'h05, 8'h22);
    wr(8'h06, 8'h33);
    wr(8'h07, 8'hEA);
    chk({31'h0, fq_ap}, 32'h1);
    chk({3'b0, fq_out}, 32'h0A332211);
    rd(8'h07, 8'h0A);
    chk({31'h0, fq_ap}, 32'h0);
    $display("freq test done");
  endtask
  task t_lock;
    wr(8'h0A, 8'h04);
    wr(8'h0B, 8'h00);
    swap_en = 1'b1;
    ref_sel = 1'b1;
    ref_valid = 1'b1;
    for (int i = 0; i < 300 && lck !== 1'b1; i++) @(negedge ref_clk);
    chk({31'h0, lck}, 32'h1);
    chk({29'h0, st}, 32'h1);
    chk({31'h0, fsel}, 32'h1);
    rd(8'h0D, 8'h13);
    rd(8'h0E, 8'h08);
    wr(8'h0E, 8'h08);
    // error well above any threshold forces a fall back to acquire
    err_abs = 24'hFFFFFF;
    repeat (15) @(negedge ref_clk);
    chk({31'h0, lck}, 32'h0);
    rd(8'h0D, 8'h42);
    rd(8'h0E, 8'h09);
    wr(8'h0E, 8'h09);
    rd(8'h0E, 8'h00);
    $display("lock test done");
  endtask
  // walks the states that only side inputs reach
  task t_modes;
    err_abs = 24'h000000;
    for (int i = 0; i < 300 && lck !== 1'b1; i++) @(negedge ref_clk);
    chk({31'h0, lck}, 32'h1);
    hl_en = 1'b1;
    hl_act = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({29'h0, st}, 32'h5);
    chk({31'h0, fsel}, 32'h1);
    hl_act = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({29'h0, st}, 32'h1);
    hl_en = 1'b0;
    ref_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({29'h0, st}, 32'h2);
    chk({31'h0, lck}, 32'h0);
    dco = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({29'h0, st}, 32'h3);
    chk({31'h0, fsel}, 32'h0);
    dco = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({29'h0, st}, 32'h0);
    $display("modes test done");
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset;
    t_phase;
    t_freq;
    t_lock;
    t_modes;
    close_out;
  end
endmodule // dpfl_lock_regs_tb_top
`default_nettype wire
